/* design/fsp_host.sv */
// Purpose: host sequencer driving a flash self-programming engine
// Assumes: device pins synchronous to clk_sys; lpm data valid the cycle after lpm_strobe
// Notes: each device access is one control write then the strobe on the next cycle
`timescale 1ns/1ns
`include "fsp_consts.svh"
module fsp_host #(
  parameter int PAGE_BITS = `FSP_PAGE_BITS,
  parameter int WORD_BITS = `FSP_WORD_BITS,
  parameter int OP_TIMEOUT = `FSP_T_OP_MAX_NS / `FSP_CLK_PERIOD_NS
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // user command port
  input wire logic cmd_valid,
  input wire fsp_pkg::fsp_op_t cmd_op,
  input wire logic [PAGE_BITS-1:0] cmd_page,
  input wire logic [WORD_BITS-1:0] cmd_word,
  input wire logic [15:0] cmd_data,
  input wire logic [3:0] cmd_lock,
  input wire logic lost_clr,
  // user answer port
  output logic cmd_busy,
  output logic rsp_done,
  output logic rsp_err,
  output logic [7:0] rsp_data,
  output logic buf_lost,
  // device pins
  output logic ctrl_wr,
  output logic [7:0] ctrl_wdata,
  output logic spm_strobe,
  output logic lpm_strobe,
  output logic [15:0] z_ptr,
  output logic [15:0] r1r0,
  input wire logic [7:0] ctrl_rdata,
  input wire logic [7:0] lpm_rdata,
  input wire logic eeprom_write_active
);

  localparam int NWORDS = 1 << WORD_BITS;

  // z pointer from page and word; low byte-select bit stays zero
  function automatic logic [15:0] make_z(input logic [PAGE_BITS-1:0] pg, input logic [WORD_BITS-1:0] wd);
    logic [31:0] full;
    full = (32'(pg) << (WORD_BITS + 1)) | (32'(wd) << 1);
    return full[15:0];
  endfunction

  fsp_tmr_if tif();

  fsp_timer #(
    .WIDTH(`FSP_TMR_WIDTH),
    .LIMIT(`FSP_TMR_WIDTH'(OP_TIMEOUT))
  ) u_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .tif(tif)
  );

  fsp_pkg::fsp_state_t state, next_state;
  fsp_pkg::fsp_op_t op, next_op;
  logic [7:0] pattern, next_pattern;
  logic [NWORDS-1:0] loaded, next_loaded;
  logic next_cmd_busy, next_rsp_done, next_rsp_err, next_buf_lost;
  logic [7:0] next_rsp_data, next_ctrl_wdata;
  logic next_ctrl_wr, next_spm_strobe, next_lpm_strobe;
  logic [15:0] next_z_ptr, next_r1r0;
  logic tmr_start;
  logic is_read;
  logic dev_enable, dev_busy;

  assign dev_enable = ctrl_rdata[`FSP_BIT_ENABLE];
  assign dev_busy = ctrl_rdata[`FSP_BIT_BUSY];
  assign is_read = (op == fsp_pkg::FSP_OP_RD_LOCK) || (op == fsp_pkg::FSP_OP_RD_FLO) ||
                   (op == fsp_pkg::FSP_OP_RD_FHI);
  assign tif.start = tmr_start;

  ////////////////////////////////////////////////////////////////////////
  // sequencer: accept, poll, eeprom check, control write, strobe, wait
  always_comb begin
    next_state = state;
    next_op = op;
    next_pattern = pattern;
    next_loaded = loaded;
    next_cmd_busy = cmd_busy;
    next_rsp_done = 1'b0;
    next_rsp_err = rsp_err;
    next_rsp_data = rsp_data;
    next_buf_lost = buf_lost;
    next_ctrl_wr = 1'b0;
    next_ctrl_wdata = ctrl_wdata;
    next_spm_strobe = 1'b0;
    next_lpm_strobe = 1'b0;
    next_z_ptr = z_ptr;
    next_r1r0 = r1r0;
    tmr_start = 1'b0;

    // lost-flag clear by user; an eeprom loss in the same cycle wins
    if (lost_clr) begin
      next_buf_lost = 1'b0;
    end
    if (eeprom_write_active && (loaded != '0)) begin
      next_loaded = '0;
      next_buf_lost = 1'b1;
    end

    unique case (state)
      fsp_pkg::FSP_ST_IDLE: begin
        if (cmd_valid) begin
          next_op = cmd_op;
          next_cmd_busy = 1'b1;
          next_rsp_err = 1'b0;
          next_r1r0 = 16'h0000;
          next_state = fsp_pkg::FSP_ST_POLL;
          tmr_start = 1'b1;
          unique case (cmd_op)
            fsp_pkg::FSP_OP_LOAD: begin
              next_pattern = `FSP_PAT_LOAD;
              next_z_ptr = make_z('0, cmd_word);
              next_r1r0 = cmd_data;
              if (loaded[cmd_word]) begin
                // second load of one word would corrupt it: refuse
                next_rsp_err = 1'b1;
                next_rsp_done = 1'b1;
                next_cmd_busy = 1'b0;
                next_state = fsp_pkg::FSP_ST_IDLE;
              end
            end
            fsp_pkg::FSP_OP_ERASE: begin
              next_pattern = `FSP_PAT_ERASE;
              next_z_ptr = make_z(cmd_page, '0);
            end
            fsp_pkg::FSP_OP_WRITE: begin
              next_pattern = `FSP_PAT_WRITE;
              next_z_ptr = make_z(cmd_page, '0);
            end
            fsp_pkg::FSP_OP_REEN: begin
              next_pattern = `FSP_PAT_REEN;
              next_z_ptr = `FSP_Z_ZERO;
            end
            fsp_pkg::FSP_OP_LOCK: begin
              next_pattern = `FSP_PAT_LOCK;
              next_z_ptr = `FSP_Z_LOCK;
              next_r1r0 = {8'h00, `FSP_LOCK_PAD_HI, cmd_lock, `FSP_LOCK_PAD_LO};
            end
            fsp_pkg::FSP_OP_RD_LOCK: begin
              next_pattern = `FSP_PAT_LOCK;
              next_z_ptr = `FSP_Z_LOCK;
            end
            fsp_pkg::FSP_OP_RD_FLO: begin
              next_pattern = `FSP_PAT_LOCK;
              next_z_ptr = `FSP_Z_FUSE_LO;
            end
            fsp_pkg::FSP_OP_RD_FHI: begin
              next_pattern = `FSP_PAT_LOCK;
              next_z_ptr = `FSP_Z_FUSE_HI;
            end
          endcase
        end
      end
      // previous operation must be finished before a new control write
      fsp_pkg::FSP_ST_POLL: begin
        if (!dev_enable) begin
          next_state = fsp_pkg::FSP_ST_EEWAIT;
        end else if (tif.expired) begin
          next_rsp_err = 1'b1;
          next_rsp_done = 1'b1;
          next_cmd_busy = 1'b0;
          next_state = fsp_pkg::FSP_ST_IDLE;
        end
      end
      // eeprom writes block programming and fuse reads, so wait them out
      fsp_pkg::FSP_ST_EEWAIT: begin
        if (!eeprom_write_active) begin
          next_ctrl_wr = 1'b1;
          next_ctrl_wdata = pattern;
          next_state = fsp_pkg::FSP_ST_STROBE;
        end
      end
      // strobe on the cycle after the control write: no gap for anything
      fsp_pkg::FSP_ST_STROBE: begin
        tmr_start = 1'b1;
        if (is_read) begin
          next_lpm_strobe = 1'b1;
          next_state = fsp_pkg::FSP_ST_RDLAT;
        end else begin
          next_spm_strobe = 1'b1;
          next_state = fsp_pkg::FSP_ST_OPWAIT;
          if (op == fsp_pkg::FSP_OP_LOAD) begin
            next_loaded[z_ptr[WORD_BITS:1]] = 1'b1;
          end
          if ((op == fsp_pkg::FSP_OP_WRITE) || (op == fsp_pkg::FSP_OP_REEN)) begin
            next_loaded = '0;
          end
        end
      end
      // enable held during the op; busy must also drop after re-enable
      fsp_pkg::FSP_ST_OPWAIT: begin
        if (!dev_enable && !(op == fsp_pkg::FSP_OP_REEN && dev_busy)) begin
          next_rsp_done = 1'b1;
          next_cmd_busy = 1'b0;
          next_state = fsp_pkg::FSP_ST_IDLE;
        end else if (tif.expired) begin
          next_rsp_err = 1'b1;
          next_rsp_done = 1'b1;
          next_cmd_busy = 1'b0;
          next_state = fsp_pkg::FSP_ST_IDLE;
        end
      end
      fsp_pkg::FSP_ST_RDLAT: begin
        next_state = fsp_pkg::FSP_ST_RDCAP;
      end
      // read byte raw: zero means programmed
      fsp_pkg::FSP_ST_RDCAP: begin
        next_rsp_data = lpm_rdata;
        next_rsp_done = 1'b1;
        next_cmd_busy = 1'b0;
        next_state = fsp_pkg::FSP_ST_IDLE;
      end
      default: begin
        next_cmd_busy = 1'b0;
        next_state = fsp_pkg::FSP_ST_IDLE;
      end
    endcase
  end

  // registers; clock enable freezes everything
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= fsp_pkg::FSP_ST_IDLE;
      op <= fsp_pkg::FSP_OP_LOAD;
      pattern <= `FSP_PAT_IDLE;
      loaded <= '0;
      cmd_busy <= 1'b0;
      rsp_done <= 1'b0;
      rsp_err <= 1'b0;
      rsp_data <= 8'h00;
      buf_lost <= 1'b0;
      ctrl_wr <= 1'b0;
      ctrl_wdata <= `FSP_PAT_IDLE;
      spm_strobe <= 1'b0;
      lpm_strobe <= 1'b0;
      z_ptr <= `FSP_Z_ZERO;
      r1r0 <= 16'h0000;
    end else if (ce) begin
      state <= next_state;
      op <= next_op;
      pattern <= next_pattern;
      loaded <= next_loaded;
      cmd_busy <= next_cmd_busy;
      rsp_done <= next_rsp_done;
      rsp_err <= next_rsp_err;
      rsp_data <= next_rsp_data;
      buf_lost <= next_buf_lost;
      ctrl_wr <= next_ctrl_wr;
      ctrl_wdata <= next_ctrl_wdata;
      spm_strobe <= next_spm_strobe;
      lpm_strobe <= next_lpm_strobe;
      z_ptr <= next_z_ptr;
      r1r0 <= next_r1r0;
    end
  end

endmodule

/* shared/fsp_consts.svh */
// Purpose: constants of the flash self-programming sequencer (host side)
// Assumes: 100 MHz system clock
// Notes: control byte layout and patterns of the device's control register
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// control register bit positions
`define FSP_BIT_ENABLE 0
`define FSP_BIT_ERASE 1
`define FSP_BIT_WRITE 2
`define FSP_BIT_LOCKSEL 3
`define FSP_BIT_REEN 4
`define FSP_BIT_BUSY 6

// control register command patterns (don't-care top bit sent as zero)
`define FSP_PAT_LOAD 8'h01
`define FSP_PAT_ERASE 8'h03
`define FSP_PAT_WRITE 8'h05
`define FSP_PAT_LOCK 8'h09
`define FSP_PAT_REEN 8'h11
`define FSP_PAT_IDLE 8'h00

// z pointer values for lock and fuse reads
`define FSP_Z_FUSE_LO 16'h0000
`define FSP_Z_LOCK 16'h0001
`define FSP_Z_FUSE_HI 16'h0003
`define FSP_Z_ZERO 16'h0000

// lock write data: bits 7,6,1,0 held at one around the 4 boot lock bits
`define FSP_LOCK_PAD_HI 2'b11
`define FSP_LOCK_PAD_LO 2'b11

// page geometry: 32 words a page, 128 pages
`define FSP_WORD_BITS 5
`define FSP_PAGE_BITS 7

// timing: longest programming operation and clock period
`define FSP_T_OP_MAX_NS 4500000
`define FSP_CLK_PERIOD_NS 10
`define FSP_TMR_WIDTH 20

`endif

/* shared/fsp_pkg.sv */
// Purpose: types of the flash self-programming sequencer
// Assumes: nothing beyond the constants header
// Notes: types only, constants live in fsp_consts.svh
package fsp_pkg;

  // user operations
  typedef enum logic [2:0] {
    FSP_OP_LOAD = 3'b000,
    FSP_OP_ERASE = 3'b001,
    FSP_OP_WRITE = 3'b010,
    FSP_OP_REEN = 3'b011,
    FSP_OP_LOCK = 3'b100,
    FSP_OP_RD_LOCK = 3'b101,
    FSP_OP_RD_FLO = 3'b110,
    FSP_OP_RD_FHI = 3'b111
  } fsp_op_t;

  // sequencer states
  typedef enum logic [2:0] {
    FSP_ST_IDLE = 3'b000,
    FSP_ST_POLL = 3'b001,
    FSP_ST_EEWAIT = 3'b010,
    FSP_ST_STROBE = 3'b011,
    FSP_ST_OPWAIT = 3'b100,
    FSP_ST_RDLAT = 3'b101,
    FSP_ST_RDCAP = 3'b110
  } fsp_state_t;

endpackage

/* shared/fsp_tmr_if.sv */
// Purpose: link between the sequencer and its timeout counter
// Assumes: one clock domain
// Notes: start is a one-cycle pulse, expired a level
`timescale 1ns/1ns
interface fsp_tmr_if;
  logic start;
  logic expired;
  modport ctl (output start, input expired);
  modport tmr (input start, output expired);
endinterface

/* design/fsp_timer.sv */
// Purpose: timeout counter for the sequencer's waits
// Assumes: start pulse reloads, clock enable freezes the count
// Notes: expired stays high until the next start
`timescale 1ns/1ns
`include "fsp_consts.svh"
module fsp_timer #(
  parameter int WIDTH = `FSP_TMR_WIDTH,
  parameter logic [WIDTH-1:0] LIMIT = 20'h6_DDD0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // control side
  fsp_tmr_if.tmr tif
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic expired;
  logic next_expired;

  ////////////////////////////////////////////////////////////////////////
  // count down from the limit, latch expiry at zero
  always_comb begin
    next_count = count;
    next_expired = expired;
    if (tif.start) begin
      next_count = LIMIT;
      next_expired = 1'b0;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end else begin
      next_expired = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      expired <= 1'b0;
    end else if (ce) begin
      count <= next_count;
      expired <= next_expired;
    end
  end

  assign tif.expired = expired;

endmodule

/* sim/fsp_host_assertions.sv */
// Purpose: port checks of the flash sequencer host
// Assumes: one clock, nrst async active low, ce held high
// Notes: bound to every fsp_host instance
`timescale 1ns/1ns
`include "fsp_consts.svh"
module fsp_host_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // device side
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic spm_strobe,
  input wire logic lpm_strobe,
  input wire logic [15:0] z_ptr,
  input wire logic [15:0] r1r0,
  input wire logic [7:0] ctrl_rdata,
  input wire logic [7:0] lpm_rdata,
  input wire logic eeprom_write_active,
  // user side
  input wire logic rsp_done,
  input wire logic [7:0] rsp_data,
  input wire logic buf_lost
);
  // one clock domain, so one default for all
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  a_ctrl_then_strobe: assert property (ctrl_wr |=> spm_strobe || lpm_strobe)
    else $error("no strobe after control write");
  a_strobe_after_ctrl: assert property (spm_strobe |-> $past(ctrl_wr) && ctrl_wdata != `FSP_PAT_IDLE)
    else $error("store strobe without control write");
  a_write_zbits: assert property (spm_strobe && ctrl_wdata == `FSP_PAT_WRITE |->
    z_ptr[5:0] == 6'h00 && z_ptr[15:13] == 3'h0) else $error("page write with stray z bits");
  a_lock_data: assert property (spm_strobe && ctrl_wdata == `FSP_PAT_LOCK |->
    r1r0[7:6] == 2'b11 && r1r0[1:0] == 2'b11 && z_ptr == `FSP_Z_LOCK) else $error("lock write data bad");
  a_ee_block: assert property (ctrl_wr |-> !$past(eeprom_write_active))
    else $error("control write during eeprom write");
  a_wait_enable: assert property (ctrl_wr |-> !$past(ctrl_rdata[`FSP_BIT_ENABLE]))
    else $error("control write while enable set");
  a_read_capture: assert property (rsp_done && $past(lpm_strobe, 2) |-> rsp_data == $past(lpm_rdata))
    else $error("read byte not captured");
  a_lpm_select: assert property (lpm_strobe |-> $past(ctrl_wr) && ctrl_wdata == `FSP_PAT_LOCK &&
    z_ptr inside {`FSP_Z_FUSE_LO, `FSP_Z_LOCK, `FSP_Z_FUSE_HI}) else $error("bad fuse or lock read");
  a_lost_cause: assert property ($rose(buf_lost) |-> $past(eeprom_write_active))
    else $error("buffer loss without eeprom write");
endmodule
bind fsp_host fsp_host_assertions u_chk (.clk_sys, .nrst, .ctrl_wr, .ctrl_wdata, .spm_strobe, .lpm_strobe,
  .z_ptr, .r1r0, .ctrl_rdata, .lpm_rdata, .eeprom_write_active, .rsp_done, .rsp_data, .buf_lost);

/* sim/fsp_dev_model.sv */
// Purpose: behavioural self-programming engine facing the host
// Assumes: control byte layout of fsp_consts.svh
// Notes: op time shortened to OPC cycles
`timescale 1ns/1ns
module fsp_dev_model #(
  parameter int OPC = 30,
  parameter logic [7:0] FUSE_LO = 8'hA5,
  parameter logic [7:0] FUSE_HI = 8'h3C
) (
  // clock, reset, eeprom state
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic eeprom_write_active,
  // core side
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic spm_strobe,
  input wire logic lpm_strobe,
  input wire logic [15:0] z_ptr,
  input wire logic [15:0] r1r0,
  output logic [7:0] ctrl_rdata,
  output logic [7:0] lpm_rdata
);
  logic [7:0] cr;
  logic busy;
  logic [3:0] blk = 4'hF;
  int win;
  int opc;
  logic [15:0] bf [0:31];
  logic [15:0] fl [0:4095];
  logic rdy_irq;
  ////////////////////////////////////////
  // status: enable in bit 0, busy in bit 6
  assign ctrl_rdata = {1'b0, busy, 1'b0, cr[4:0]};
  // ready request is a level, held while the enable bit reads clear
  assign rdy_irq = ~cr[0];
  // arming window, ops and buffer
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cr <= 8'h00;
      busy <= 1'b0;
      win <= 0;
      opc <= 0;
      lpm_rdata <= 8'h00;
      foreach (bf[i]) bf[i] <= 16'hFFFF;
    end else begin
      lpm_rdata <= ~lpm_rdata; // no stale byte between reads
      if (win > 0) win <= win - 1;
      if (win == 1 && opc == 0) cr[3:0] <= 4'h0;
      if (opc > 1) opc <= opc - 1;
      if (opc == 1) begin
        opc <= 0;
        cr[3:0] <= 4'h0;
      end
      if (eeprom_write_active) foreach (bf[i]) bf[i] <= 16'hFFFF;
      if (ctrl_wr && !eeprom_write_active) begin
        cr <= ctrl_wdata;
        win <= 4;
      end else if (spm_strobe && win > 0) begin
        win <= 0;
        case (cr[4:0])
          5'h01: begin
            bf[z_ptr[5:1]] <= r1r0;
            cr[0] <= 1'b0;
          end
          5'h03: begin
            for (int i = 0; i < 32; i++) fl[{z_ptr[12:6], i[4:0]}] <= 16'hFFFF;
            busy <= 1'b1;
            opc <= OPC;
          end
          5'h05: begin
            for (int i = 0; i < 32; i++) fl[{z_ptr[12:6], i[4:0]}] <= bf[i];
            foreach (bf[i]) bf[i] <= 16'hFFFF;
            busy <= 1'b1;
            opc <= OPC;
          end
          5'h09: begin
            blk <= blk & r1r0[5:2];
            opc <= OPC;
          end
          5'h11: begin
            busy <= 1'b0;
            foreach (bf[i]) bf[i] <= 16'hFFFF;
            cr[4:0] <= 5'h00;
          end
          default: cr[4:0] <= 5'h00;
        endcase
      end else if (lpm_strobe && win > 1 && cr[3]) begin
        win <= 0;
        cr[3:0] <= 4'h0;
        // programmed reads 0, unprogrammed 1
        case (z_ptr)
          16'h0000: lpm_rdata <= FUSE_LO;
          16'h0001: lpm_rdata <= {2'b11, blk, 2'b11};
          16'h0003: lpm_rdata <= FUSE_HI;
          default: lpm_rdata <= 8'hFF;
        endcase
      end
    end
  end
endmodule

/* sim/tb_top.sv */
// Purpose: self-checking bench of the flash sequencer host
// Assumes: device model with 30-cycle ops, host timeout 60
// Notes: ce tied high; one task per scenario
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_top;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  fsp_pkg::fsp_op_t cmd_op = fsp_pkg::FSP_OP_LOAD;
  logic [6:0] cmd_page = 7'h00;
  logic [4:0] cmd_word = 5'h00;
  logic [15:0] cmd_data = 16'h0000;
  logic [3:0] cmd_lock = 4'hF;
  logic lost_clr = 1'b0;
  logic eeprom_write_active = 1'b0;
  logic cmd_busy, rsp_done, rsp_err, buf_lost, ctrl_wr, spm_strobe, lpm_strobe;
  logic [7:0] rsp_data, ctrl_wdata, ctrl_rdata, lpm_rdata;
  logic [15:0] z_ptr, r1r0;
  int num_errors = 0;
  int n_compared = 0;
  int ncyc;
  int nwr = 0;
  ////////////////////////////////////////
  fsp_host #(.OP_TIMEOUT(60)) dut (.clk_sys, .nrst, .ce(1'b1), .cmd_valid, .cmd_op, .cmd_page, .cmd_word,
    .cmd_data, .cmd_lock, .lost_clr, .cmd_busy, .rsp_done, .rsp_err, .rsp_data, .buf_lost, .ctrl_wr,
    .ctrl_wdata, .spm_strobe, .lpm_strobe, .z_ptr, .r1r0, .ctrl_rdata, .lpm_rdata, .eeprom_write_active);
  fsp_dev_model #(.OPC(30)) dev (.clk_sys, .nrst, .eeprom_write_active, .ctrl_wr, .ctrl_wdata,
    .spm_strobe, .lpm_strobe, .z_ptr, .r1r0, .ctrl_rdata, .lpm_rdata);
  // clock and control-write counter
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (ctrl_wr) nwr++;
  // verdict and end of run
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one command, waits for its completion pulse
  task automatic cmd(input fsp_pkg::fsp_op_t op, input logic [6:0] pg, input logic [4:0] wd,
                     input logic [15:0] dt, input logic [3:0] lk);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_page <= pg;
    cmd_word <= wd;
    cmd_data <= dt;
    cmd_lock <= lk;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    ncyc = 0;
    do begin @(negedge clk_sys); ncyc++; end while (!rsp_done && ncyc < 3000);
    `CHK("rsp_done", 1'b1, rsp_done)
    // busy must drop on the same edge that raises the done pulse
    `CHK("cmd_busy", 1'b0, cmd_busy)
  endtask
  // fuse and lock bytes read back as preset
  task automatic t_fuse;
    cmd(fsp_pkg::FSP_OP_RD_FLO, 0, 0, 0, 0); `CHK("fuse_low_byte", 8'hA5, rsp_data)
    cmd(fsp_pkg::FSP_OP_RD_FHI, 0, 0, 0, 0); `CHK("fuse_high_byte", 8'h3C, rsp_data)
    cmd(fsp_pkg::FSP_OP_RD_LOCK, 0, 0, 0, 0); `CHK("lock byte", 8'hFF, rsp_data)
    `CHK("ready irq", 1'b1, dev.rdy_irq)
    $display("test fuse done");
  endtask
  // lock bits take a full op time, zeros programmed
  task automatic t_lock;
    cmd(fsp_pkg::FSP_OP_LOCK, 0, 0, 0, 4'b0110);
    `CHK("lock op long", 1'b1, ncyc >= 30)
    cmd(fsp_pkg::FSP_OP_RD_LOCK, 0, 0, 0, 0); `CHK("lock byte", 8'b1101_1011, rsp_data)
    $display("test lock done");
  endtask
  // erase, re-enable, load with a duplicate, write
  task automatic t_page;
    cmd(fsp_pkg::FSP_OP_ERASE, 5, 0, 0, 0); `CHK("busy after erase", 1'b1, ctrl_rdata[6])
    cmd(fsp_pkg::FSP_OP_REEN, 0, 0, 0, 0); `CHK("busy after reen", 1'b0, ctrl_rdata[6])
    cmd(fsp_pkg::FSP_OP_LOAD, 5, 31, 16'h1234, 0); `CHK("load err", 1'b0, rsp_err)
    cmd(fsp_pkg::FSP_OP_LOAD, 5, 0, 16'hABCD, 0);
    cmd(fsp_pkg::FSP_OP_LOAD, 5, 31, 16'h5555, 0); `CHK("dup load err", 1'b1, rsp_err)
    cmd(fsp_pkg::FSP_OP_WRITE, 5, 0, 0, 0); `CHK("word 31", 16'h1234, dev.fl[{7'd5, 5'd31}])
    `CHK("word 0", 16'hABCD, dev.fl[{7'd5, 5'd0}])
    cmd(fsp_pkg::FSP_OP_LOAD, 5, 31, 16'h0001, 0); `CHK("reload err", 1'b0, rsp_err)
    cmd(fsp_pkg::FSP_OP_REEN, 0, 0, 0, 0);
    $display("test page done");
  endtask
  // eeprom write loses the buffer and stalls an erase
  task automatic t_ee;
    int w;
    cmd(fsp_pkg::FSP_OP_LOAD, 6, 2, 16'h00AA, 0);
    @(posedge clk_sys) eeprom_write_active <= 1'b1;
    // look between edges, where the lost flag has settled
    repeat (3) @(negedge clk_sys);
    `CHK("buf_lost", 1'b1, buf_lost)
    w = nwr;
    fork
      cmd(fsp_pkg::FSP_OP_ERASE, 6, 0, 0, 0);
      begin
        repeat (30) @(posedge clk_sys);
        `CHK("writes in eeprom wait", w, nwr)
        eeprom_write_active <= 1'b0;
      end
    join
    `CHK("erase err", 1'b0, rsp_err)
    @(posedge clk_sys) lost_clr <= 1'b1;
    @(posedge clk_sys) lost_clr <= 1'b0;
    @(negedge clk_sys) `CHK("buf_lost clr", 1'b0, buf_lost)
    cmd(fsp_pkg::FSP_OP_REEN, 0, 0, 0, 0);
    $display("test eeprom done");
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    t_fuse();
    t_lock();
    t_page();
    t_ee();
    tally_and_finish();
  end
  // hang guard, well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    tally_and_finish();
  end
endmodule
